/* lfm_regs.svh */
// Register offsets, field positions and reset values of the fault mask block
// Operation
// - 12-bit per-LED mask stops open and short faults of that LED reaching pin.
// - Status bit 4 reads 1 once resistor decoding has completed.
// - Status bit 3 set when address resistor is over range or open.
// - Status bit 2 set when grade resistor is over range or open.
// - Status bit 1 set when address resistor is under range or shorted.
// - Status bit 0 set when grade resistor is under range or shorted.
// - Decoded grade value reads in bits 3:0 of decoded-code register.
// - Read-pending bit 8 of general status stays high until resistor decoding has completed.
// - Summary flag_a flag is high while any per-LED open bit is high.
`ifndef LFM_REGS_SVH
`define LFM_REGS_SVH
`define LFM_ADDR_W          8
`define LFM_DATA_W          13
`define LFM_OFS_MASK        8'h0d
`define LFM_OFS_RSTAT       8'h0e
`define LFM_OFS_CODES       8'h0f
`define LFM_OFS_GSTAT       8'h10
`define LFM_MASK_RST        12'h000
`define LFM_BIT_DONE        4
`define LFM_BIT_ADDR_HI     3
`define LFM_BIT_GRADE_HI    2
`define LFM_BIT_ADDR_LO     1
`define LFM_BIT_GRADE_LO    0
`define LFM_BIT_PENDING     8
`define LFM_BIT_OPEN        4
`define LFM_BIT_SHORT       3
`endif

/* lfm_pkg.sv */
// Types shared by the fault mask block
package lfm_pkg;
   // Outcome of one resistor measurement
   typedef struct packed {
      logic       addr_too_high;
      logic       grade_too_high;
      logic       addr_too_low;
      logic       grade_too_low;
      logic [3:0] address_select_resistor;
      logic [3:0] grade_code;
   } lfm_meas_t;
   // Register access request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [12:0] wdata;
   } lfm_req_t;
endpackage

/* lfm_fault_combine.sv */
// Masks per-LED faults and forms the summary flags
`timescale 1ns/1ps
`include "lfm_regs.svh"
module lfm_fault_combine #(
   parameter int N_LED = 12
) (
   input  wire logic [N_LED-1:0] i_open,
   input  wire logic [N_LED-1:0] i_short,
   input  wire logic [N_LED-1:0] i_mask,
   output logic                  o_flag_a,
   output logic                  o_flag_b,
   output logic                  o_led_fault
);
   // Summary flags see every LED; the pin sees only unmasked ones
   assign o_flag_a    = |i_open;
   assign o_flag_b    = |i_short;
   assign o_led_fault = |((i_open | i_short) & ~i_mask);
endmodule

/* lfm_top.sv */
// Fault mask, resistor decode status and decoded code registers
`timescale 1ns/1ps
`include "lfm_regs.svh"
module lfm_top #(
   parameter int N_LED = 12
) (
   input  wire logic             i_clk,
   input  wire logic             i_rstn,
   input  wire lfm_pkg::lfm_req_t i_req,
   output logic [12:0]           o_rdata,
   input  wire logic [N_LED-1:0] i_per_led_open_status,
   input  wire logic [N_LED-1:0] i_per_led_short_status,
   input  wire logic             i_meas_valid,
   input  wire lfm_pkg::lfm_meas_t i_meas,
   input  wire logic             i_other_fault,
   output logic [3:0]            o_unit_address_code,
   output logic                  o_resistor_read_pending,
   output logic                  o_flag_a,
   output logic                  o_flag_b,
   output logic                  o_fault_pin_n
);
   ////////////////////////////////////////////////////////////////////////
   logic [N_LED-1:0]  per_led_fault_mask_q;
   logic              resistor_decode_done_q;
   lfm_pkg::lfm_meas_t meas_q;
   logic              led_fault;
   logic              fault_n_q;
   logic [12:0]       rdata_q;
   logic [12:0]       rstat_w;
   logic [12:0]       codes_w;
   logic [12:0]       gstat_w;
   logic              wr_mask;
   logic              sel_mask;
   logic              sel_rstat;
   logic              sel_codes;
   logic              sel_gstat;
   logic [12:0]       mask_img;
   logic [12:0]       rdata_d;

   // Offset match, shared by the write strobe and the read selection
   function automatic logic addr_hit(input logic [7:0] a,
                                     input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // Register selects; only the mask register takes writes
   assign sel_mask  = addr_hit(i_req.addr, `LFM_OFS_MASK);
   assign sel_rstat = addr_hit(i_req.addr, `LFM_OFS_RSTAT);
   assign sel_codes = addr_hit(i_req.addr, `LFM_OFS_CODES);
   assign sel_gstat = addr_hit(i_req.addr, `LFM_OFS_GSTAT);
   assign wr_mask   = i_req.wr && sel_mask;

   // Mask register
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         per_led_fault_mask_q <= `LFM_MASK_RST;
      else if (wr_mask)
         per_led_fault_mask_q <= i_req.wdata[N_LED-1:0];
   end

   // Mask register: a write lands whole, nothing else moves it
   a_mask_write: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      wr_mask |=> per_led_fault_mask_q == $past(i_req.wdata[N_LED-1:0]))
      else $error("mask write lost");
   a_mask_hold: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      !wr_mask |=> $stable(per_led_fault_mask_q))
      else $error("mask changed without write");

   ////////////////////////////////////////////////////////////////////////
   // Measurement capture; no bus path writes these
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         resistor_decode_done_q <= 1'b0;
         meas_q                 <= '0;
      end
      else if (i_meas_valid)
      begin
         resistor_decode_done_q <= 1'b1;
         meas_q                 <= i_meas;
      end
   end

   assign o_unit_address_code     = meas_q.address_select_resistor;
   assign o_resistor_read_pending = ~resistor_decode_done_q;

   // Capture: done is sticky, flags and codes follow each measurement
   a_done_set: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_meas_valid |=> resistor_decode_done_q)
      else $error("done not set");
   a_done_sticky: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      resistor_decode_done_q |=> resistor_decode_done_q)
      else $error("done fell");
   a_flags_hold: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      !i_meas_valid |=> $stable(meas_q))
      else $error("flags changed without measurement");
   a_flags_cap: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_meas_valid |=> rstat_w[3:0] == $past({i_meas.addr_too_high,
         i_meas.grade_too_high, i_meas.addr_too_low,
         i_meas.grade_too_low}))
      else $error("range flags wrong");
   a_high_flags: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_meas_valid |=> meas_q.addr_too_high == $past(i_meas.addr_too_high)
         && meas_q.grade_too_high == $past(i_meas.grade_too_high))
      else $error("over range flags wrong");
   a_low_flags: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_meas_valid |=> meas_q.addr_too_low == $past(i_meas.addr_too_low)
         && meas_q.grade_too_low == $past(i_meas.grade_too_low))
      else $error("under range flags wrong");
   a_codes_cap: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_meas_valid |=> meas_q.grade_code == $past(i_meas.grade_code)
         && o_unit_address_code
            == $past(i_meas.address_select_resistor))
      else $error("decoded codes not captured");
   a_ro_writes: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_req.wr && !i_meas_valid) |=> $stable(meas_q)
         && $stable(resistor_decode_done_q))
      else $error("bus write reached decode status");

   ////////////////////////////////////////////////////////////////////////
   lfm_fault_combine #(
      .N_LED (N_LED)
   ) u_comb (
      .i_open      (i_per_led_open_status),
      .i_short     (i_per_led_short_status),
      .i_mask      (per_led_fault_mask_q),
      .o_flag_a    (o_flag_a),
      .o_flag_b    (o_flag_b),
      .o_led_fault (led_fault)
   );

   // Read images
   assign rstat_w = {8'h00, resistor_decode_done_q, meas_q.addr_too_high,
                     meas_q.grade_too_high, meas_q.addr_too_low,
                     meas_q.grade_too_low};
   assign codes_w = {5'h00, meas_q.address_select_resistor,
                     meas_q.grade_code};
   assign gstat_w = {4'h0, ~resistor_decode_done_q, 3'h0, o_flag_a,
                     o_flag_b, 3'h0};

   // Read selection; an unmapped offset reads as zero
   assign mask_img = 13'(per_led_fault_mask_q);
   assign rdata_d  = sel_mask  ? mask_img :
                     sel_rstat ? rstat_w  :
                     sel_codes ? codes_w  :
                     sel_gstat ? gstat_w  : 13'h0000;

   // Read data register; holds between reads
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         rdata_q <= 13'h0000;
      else if (i_req.rd)
         rdata_q <= rdata_d;
   end

   // Fault pin register, low for any unmasked fault or pending decode
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         fault_n_q <= 1'b1;
      else
         fault_n_q <= ~(led_fault | ~resistor_decode_done_q
                        | i_other_fault);
   end

   assign o_rdata       = rdata_q;
   assign o_fault_pin_n = fault_n_q;

   ////////////////////////////////////////////////////////////////////////
   // Reads return the image of the register addressed one edge earlier
   a_mask_read: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_req.rd && sel_mask)
      |=> o_rdata == 13'($past(per_led_fault_mask_q)))
      else $error("mask read wrong");
   a_status_read: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_req.rd && sel_rstat)
      |=> o_rdata == {8'h00, $past(resistor_decode_done_q),
                      $past(meas_q[11:8])})
      else $error("decode status read wrong");
   a_code_read: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_req.rd && sel_codes)
      |=> o_rdata == {5'h00, $past(meas_q.address_select_resistor),
                      $past(meas_q.grade_code)})
      else $error("code read wrong");
   a_pending_read: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_req.rd && sel_gstat)
      |=> o_rdata[`LFM_BIT_PENDING] == !$past(resistor_decode_done_q))
      else $error("pending bit read wrong");
   a_summary_read: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_req.rd && sel_gstat)
      |=> o_rdata[`LFM_BIT_OPEN] == $past(o_flag_a))
      else $error("open summary read wrong");

   // Fault pin: masked faults stay off it, the rest pull it low
   a_mask_blocks: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (resistor_decode_done_q && !i_other_fault
       && ((i_per_led_open_status | i_per_led_short_status)
           & ~per_led_fault_mask_q) == '0) |=> o_fault_pin_n)
      else $error("masked fault reached pin");
   a_fault_pin: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (((i_per_led_open_status | i_per_led_short_status)
        & ~per_led_fault_mask_q) != '0) |=> !o_fault_pin_n)
      else $error("unmasked fault missed pin");
   a_pending_pin: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      !resistor_decode_done_q |=> !o_fault_pin_n)
      else $error("pending did not assert pin");
   a_open_sum: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (i_per_led_open_status != '0) == o_flag_a)
      else $error("open summary wrong");
endmodule

/* lfm_host_model.sv */
// Host model that issues register requests to the fault mask block
`timescale 1ns/1ps
module lfm_host_model (
   input  wire logic         i_clk,
   input  wire logic [12:0]  i_rdata,
   output lfm_pkg::lfm_req_t o_req
);
   initial o_req = '0;
   // One request per call, raised and dropped at falling edges
   task automatic wr(input logic [7:0] a, input logic [12:0] d);
      @(negedge i_clk);
      o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge i_clk);
      o_req = '0;
   endtask
   // Read data is settled one edge after the request is taken
   task automatic rd(input logic [7:0] a, output logic [12:0] d);
      @(negedge i_clk);
      o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 13'h0000};
      @(negedge i_clk);
      o_req = '0;
      d = i_rdata;
   endtask
endmodule

/* testbench.sv */
// Self-checking testbench of the fault mask block
`timescale 1ns/1ps
module testbench;
   logic               i_clk;
   logic               i_rstn;
   logic               meas_valid;
   logic               other_fault;
   logic [11:0]        open_st;
   logic [11:0]        short_st;
   lfm_pkg::lfm_meas_t meas;
   lfm_pkg::lfm_req_t  req;
   logic [12:0]        rdata;
   logic [12:0]        v;
   logic [3:0]         unit_addr;
   logic               pending;
   logic               flag_a;
   logic               flag_b;
   logic               pin_n;
   int                 fail_count = 0;
   int                 n_checks = 0;
   ////////////////////////////////////////////////////////////////////////////
   lfm_host_model u_host (.i_clk(i_clk), .i_rdata(rdata), .o_req(req));
   lfm_top #(.N_LED(12)) DUT (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_req(req), .o_rdata(rdata),
      .i_per_led_open_status(open_st), .i_per_led_short_status(short_st),
      .i_meas_valid(meas_valid), .i_meas(meas), .i_other_fault(other_fault),
      .o_unit_address_code(unit_addr), .o_resistor_read_pending(pending),
      .o_flag_a(flag_a), .o_flag_b(flag_b), .o_fault_pin_n(pin_n));
   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Reset values, then writes aimed at read-only places and a read of an unmapped place
   task automatic t_reset_ro();
      u_host.rd(8'h0d, v); check(v, 13'h0000);
      u_host.rd(8'h0e, v); check(v, 13'h0000);
      check({12'h000, pending}, 13'h0001);
      check({12'h000, pin_n}, 13'h0000);
      u_host.wr(8'h0e, 13'h1fff);
      u_host.wr(8'h0f, 13'h1fff);
      u_host.rd(8'h0e, v); check(v, 13'h0000);
      u_host.rd(8'h0f, v); check(v, 13'h0000);
      u_host.rd(8'h20, v); check(v, 13'h0000);
   endtask
   // One measurement pulse and the readback of flags and codes
   task automatic t_meas(input lfm_pkg::lfm_meas_t m, input logic [4:0] st);
      meas = m;
      meas_valid = 1'b1;
      cyc(1);
      meas_valid = 1'b0;
      u_host.wr(8'h0e, 13'h1fff);
      u_host.wr(8'h0f, 13'h1fff);
      u_host.rd(8'h0e, v); check(v, {8'h00, st});
      u_host.rd(8'h0f, v); check(v, {5'h00, m[7:0]});
      check({9'h000, unit_addr}, {9'h000, m[7:4]});
      u_host.rd(8'h10, v); check(v & 13'h0100, 13'h0000);
   endtask
   // Per-LED mask against open and short faults at the pin
   task automatic t_mask();
      open_st = 12'h020;
      cyc(3); check({12'h000, pin_n}, 13'h0000);
      u_host.wr(8'h0d, 13'h1020);
      cyc(3); check({12'h000, pin_n}, 13'h0001);
      check({12'h000, flag_a}, 13'h0001);
      u_host.rd(8'h0d, v); check(v, 13'h0020);
      short_st = 12'h020;
      cyc(3); check({12'h000, pin_n}, 13'h0001);
      short_st = 12'h060;
      cyc(3); check({12'h000, pin_n}, 13'h0000);
      check({12'h000, flag_b}, 13'h0001);
      u_host.rd(8'h10, v);
      check(v & 13'h0018, 13'h0018);
      open_st = 12'h000;
      short_st = 12'h000;
      cyc(3);
      check({12'h000, pin_n}, 13'h0001);
      other_fault = 1'b1;
      cyc(3);
      check({12'h000, pin_n}, 13'h0000);
      other_fault = 1'b0;
      cyc(3);
      check({12'h000, pin_n}, 13'h0001);
   endtask
   // Reset in mid-run clears the mask and the decode state again
   task automatic t_rereset();
      u_host.wr(8'h0d, 13'h0fff);
      i_rstn = 1'b0;
      cyc(2);
      i_rstn = 1'b1;
      cyc(2);
      check({12'h000, pending}, 13'h0001);
      check({12'h000, pin_n}, 13'h0000);
      u_host.rd(8'h0d, v);
      check(v, 13'h0000);
      u_host.rd(8'h0e, v);
      check(v, 13'h0000);
      u_host.rd(8'h0f, v);
      check(v, 13'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      i_rstn = 1'b0;
      meas_valid = 1'b0;
      other_fault = 1'b0;
      open_st = 12'h000;
      short_st = 12'h000;
      meas = '0;
      cyc(8);
      i_rstn = 1'b1;
      cyc(2);
      t_reset_ro();
      t_meas('{1'b1, 1'b0, 1'b1, 1'b0, 4'ha, 4'h5}, 5'h1a);
      t_meas('{1'b0, 1'b1, 1'b0, 1'b1, 4'h3, 4'hc}, 5'h15);
      t_mask();
      t_rereset();
      print_verdict();
   end
endmodule
